// >>> logic/tcmp_top.sv
// Operation
// - enable bit powers comparator; disabled comparator yields no result or event
// - pin-drive bit routes result to output pin, else internal only
// - invert bit flips result; result bit reads plus-above-minus when not inverted
// - selected edge sets sticky event flag; set flag blocks further events
// - edge select 11 makes events on any result change while flag clear
// - edge select 10: falling raw edge, or rising when inverted
// - edge select 01: rising raw edge, or falling when inverted
// - edge select 00 makes no event
// - plus-input select picks internal reference when set, pin A when clear
// - minus-input select: 00 pin B, 01 pin C, 10 pin D, 11 half band gap
// - idle-stop bit halts all comparators during idle mode
// - status bits 10..8 mirror event flags of comparators 3..1
// - status bits 2..0 mirror results of comparators 3..1
// - unimplemented bits read zero; all implemented bits reset to zero
// - reference power bit powers the reference ladder
// - reference pin-drive bit puts reference voltage on its pin
// - range bit selects fine (/24) or offset (/32) reference range
// - supply select bit picks external reference pins or analog supply
// - four-bit level sets reference voltage within selected range
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
module tcmp_top
    import tcmp_pkg::*;
#(
    parameter int N = NUM_CMP
)(
    input  wire logic              clk_sys,
    input  wire logic              rst_b,
    input  wire logic              idleMode,
    input  wire logic [N-1:0]      cmpRaw,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic [N-1:0]           cmpOn,
    output logic [N-1:0]           cmpInvert,
    output logic [N-1:0]           plusInputSelect,
    output logic [2*N-1:0]         minusInputSelect,
    output logic [N-1:0]           cmpOutputPin,
    output logic [N-1:0]           cmpPinDriveEn,
    output logic [N-1:0]           cmpIrq,
    output logic [N-1:0]           cmpTrigger,
    output logic                   refPower,
    output logic                   refPinDrive,
    output logic                   refRange,
    output logic                   refSupplySelect,
    output logic [3:0]             refLevel
);

    typedef struct packed {
        logic [N-1:0][15:0] ctl;
        logic               idleStop;
        logic [7:0]         refCtl;
        logic [N-1:0]       sync1;
        logic [N-1:0]       sync2;
        logic [N-1:0]       prevRes;
        logic [N-1:0]       active;
        logic [N-1:0]       outPin;
        logic [N-1:0]       pinEn;
        logic [N-1:0]       irq;
        logic               awHeld;
        logic [ADDR_W-1:0]  awAddr;
        logic               wHeld;
        logic [31:0]        wData;
        logic [3:0]         wStrb;
        logic               bValid;
        logic [1:0]         bResp;
        logic               rValid;
        logic [31:0]        rData;
        logic [1:0]         rResp;
    } tcmp_state_t;

    tcmp_state_t state_reg;
    tcmp_state_t state_next;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] strb, input logic [15:0] wmask);
        logic [15:0] m;
        m = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
        return (old & ~m) | (d[15:0] & m);
    endfunction

    function automatic logic [15:0] readReg(input tcmp_state_t s, input logic [ADDR_W-1:0] a,
                                            output logic ok);
        logic [15:0] v;
        v = 16'h0000;
        ok = 1'b1;
        unique case (a)
            {1'b0, ADDR_CTRL1}: v = s.ctl[0];
            {1'b0, ADDR_CTRL2}: v = s.ctl[1];
            {1'b0, ADDR_CTRL3}: v = s.ctl[2];
            {1'b0, ADDR_STATUS}:
            begin
                v[STAT_IDLE] = s.idleStop;
                for (int i = 0; i < N; i++)
                begin
                    v[STAT_EVT_LO + i] = s.ctl[i][CTL_EVT];
                    v[STAT_RES_LO + i] = s.ctl[i][CTL_RES];
                end
            end
            ADDR_REF: v = {8'h00, s.refCtl};
            default: ok = 1'b0;
        endcase
        return v;
    endfunction

    always_comb
    begin
        logic        res;
        logic        rise;
        logic        fall;
        logic        hit;
        logic        ok;
        logic [1:0]  sel;
        logic        doWrite;
        logic [15:0] rv;
        res = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        hit = 1'b0;
        ok = 1'b0;
        sel = EDGE_NONE;
        doWrite = 1'b0;
        rv = 16'h0000;
        state_next = state_reg;

        // two-stage synchroniser on the analog results
        state_next.sync1 = cmpRaw;
        state_next.sync2 = state_reg.sync1;

        // bus write channel capture
        if (s_axi_awvalid && !state_reg.awHeld)
        begin
            state_next.awHeld = 1'b1;
            state_next.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !state_reg.wHeld)
        begin
            state_next.wHeld = 1'b1;
            state_next.wData = s_axi_wdata;
            state_next.wStrb = s_axi_wstrb;
        end
        // address and data stay held until the response is taken, so no new write overlaps
        if (state_reg.bValid && s_axi_bready)
        begin
            state_next.bValid = 1'b0;
            state_next.awHeld = 1'b0;
            state_next.wHeld = 1'b0;
        end
        doWrite = state_reg.awHeld && state_reg.wHeld && !state_reg.bValid;

        for (int i = 0; i < N; i++)
        begin
            state_next.irq[i] = 1'b0;
            // comparator runs when enabled and not stopped by idle
            state_next.active[i] = state_reg.ctl[i][CTL_ON]
                                   && !(state_reg.idleStop && idleMode);
            res = state_reg.active[i] && (state_reg.sync2[i] ^ state_reg.ctl[i][CTL_INV]);
            state_next.ctl[i][CTL_RES] = res;
            state_next.prevRes[i] = res;
            rise = res && !state_reg.prevRes[i];
            fall = !res && state_reg.prevRes[i];
            sel = state_reg.ctl[i][CTL_EDGE_HI:CTL_EDGE_LO];
            unique case (sel)
                EDGE_ANY:  hit = rise || fall;
                EDGE_FALL: hit = state_reg.ctl[i][CTL_INV] ? rise : fall;
                EDGE_RISE: hit = state_reg.ctl[i][CTL_INV] ? fall : rise;
                EDGE_NONE: hit = 1'b0;
            endcase
            hit = hit && state_reg.active[i];
            // output pin follows the result only when pin drive is set
            state_next.outPin[i] = state_reg.ctl[i][CTL_PIN] && res;
            state_next.pinEn[i] = !state_reg.ctl[i][CTL_PIN];
            if (doWrite && state_reg.awAddr == {1'b0, 4'(i * 4)})
            begin
                state_next.ctl[i] = merge16(state_reg.ctl[i], state_reg.wData,
                                            state_reg.wStrb, CTL_WMASK);
                state_next.ctl[i][CTL_RES] = res;
            end
            if (hit && !state_reg.ctl[i][CTL_EVT])
            begin
                state_next.ctl[i][CTL_EVT] = 1'b1;
                state_next.irq[i] = 1'b1;
            end
        end

        if (doWrite)
        begin
            state_next.bValid = 1'b1;
            state_next.bResp = RESP_OKAY;
            if (state_reg.awAddr == {1'b0, ADDR_STATUS})
            begin
                if (state_reg.wStrb[1])
                begin
                    state_next.idleStop = state_reg.wData[STAT_IDLE];
                end
            end
            else if (state_reg.awAddr == ADDR_REF)
            begin
                state_next.refCtl = 8'(merge16({8'h00, state_reg.refCtl}, state_reg.wData,
                                              state_reg.wStrb, REF_WMASK));
            end
            else if (state_reg.awAddr != {1'b0, ADDR_CTRL1}
                     && state_reg.awAddr != {1'b0, ADDR_CTRL2}
                     && state_reg.awAddr != {1'b0, ADDR_CTRL3})
            begin
                state_next.bResp = RESP_SLVERR;
            end
        end

        // read channel: one cycle to answer
        if (state_reg.rValid && s_axi_rready)
        begin
            state_next.rValid = 1'b0;
        end
        if (s_axi_arvalid && !state_reg.rValid)
        begin
            rv = readReg(state_reg, s_axi_araddr, ok);
            state_next.rValid = 1'b1;
            state_next.rData = {16'h0000, rv};
            state_next.rResp = ok ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            state_reg <= '0;
            state_reg.pinEn <= '1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign s_axi_awready = !state_reg.awHeld;
    assign s_axi_wready = !state_reg.wHeld;
    assign s_axi_bvalid = state_reg.bValid;
    assign s_axi_bresp = state_reg.bResp;
    assign s_axi_arready = !state_reg.rValid;
    assign s_axi_rvalid = state_reg.rValid;
    assign s_axi_rdata = state_reg.rData;
    assign s_axi_rresp = state_reg.rResp;

    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            cmpOn[i] = state_reg.active[i];
            cmpInvert[i] = state_reg.ctl[i][CTL_INV];
            plusInputSelect[i] = state_reg.ctl[i][CTL_PLUS];
            minusInputSelect[2*i +: 2] = state_reg.ctl[i][CTL_MINUS_HI:CTL_MINUS_LO];
        end
    end

    assign cmpOutputPin = state_reg.outPin;
    assign cmpPinDriveEn = state_reg.pinEn;
    assign cmpIrq = state_reg.irq;
    assign cmpTrigger = state_reg.irq;
    assign refPower = state_reg.refCtl[REF_POWER];
    assign refPinDrive = state_reg.refCtl[REF_PIN];
    assign refRange = state_reg.refCtl[REF_RANGE];
    assign refSupplySelect = state_reg.refCtl[REF_SUPPLY];
    assign refLevel = state_reg.refCtl[3:0];

endmodule

// >>> common/tcmp_pkg.sv
package tcmp_pkg;

    localparam int NUM_CMP = 3;

    // register byte addresses
    localparam logic [3:0] ADDR_CTRL1  = 4'h0;
    localparam logic [3:0] ADDR_CTRL2  = 4'h4;
    localparam logic [3:0] ADDR_CTRL3  = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hC;
    localparam logic [4:0] ADDR_REF    = 5'h10;
    localparam int ADDR_W = 5;

    // comparator control fields
    localparam int CTL_ON      = 15;
    localparam int CTL_PIN     = 14;
    localparam int CTL_INV     = 13;
    localparam int CTL_EVT     = 9;
    localparam int CTL_RES     = 8;
    localparam int CTL_EDGE_HI = 7;
    localparam int CTL_EDGE_LO = 6;
    localparam int CTL_PLUS    = 4;
    localparam int CTL_MINUS_HI = 1;
    localparam int CTL_MINUS_LO = 0;
    localparam logic [15:0] CTL_WMASK = 16'hE2D3;

    // status fields
    localparam int STAT_IDLE    = 15;
    localparam int STAT_EVT_LO  = 8;
    localparam int STAT_RES_LO  = 0;

    // reference fields
    localparam logic [15:0] REF_WMASK = 16'h00FF;
    localparam int REF_POWER  = 7;
    localparam int REF_PIN    = 6;
    localparam int REF_RANGE  = 5;
    localparam int REF_SUPPLY = 4;

    localparam logic [1:0] EDGE_NONE = 2'b00;
    localparam logic [1:0] EDGE_RISE = 2'b01;
    localparam logic [1:0] EDGE_FALL = 2'b10;
    localparam logic [1:0] EDGE_ANY  = 2'b11;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// >>> test/tcmp_checker.sv
module tcmp_checker
    import tcmp_pkg::*;
#(
    parameter int N = NUM_CMP
)(
    input wire logic         clk_sys,
    input wire logic         rst_b,
    input wire logic [N-1:0] cmpOn,
    input wire logic [N-1:0] cmpIrq,
    input wire logic [N-1:0] cmpTrigger,
    input wire logic         s_axi_awready,
    input wire logic         s_axi_wready,
    input wire logic         s_axi_bvalid,
    input wire logic         s_axi_bready,
    input wire logic         s_axi_arvalid,
    input wire logic         s_axi_arready,
    input wire logic         s_axi_rvalid,
    input wire logic         s_axi_rready,
    input wire logic [31:0]  s_axi_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence rd_answer;
        s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000;
    endsequence
    rd_answer_a: assert property (rd_taken |=> rd_answer)
        else $error("read answer late or upper half set");
    r_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer not released");
    w_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");
    irq_pair_a: assert property (cmpIrq == cmpTrigger)
        else $error("interrupt and trigger differ");
    irq_single_a: assert property (|cmpIrq |=> (cmpIrq & $past(cmpIrq)) == '0)
        else $error("interrupt longer than one cycle");
    // a halted comparator may still interrupt for up to four cycles after cmpOn was last high
    off_quiet_a: assert property ((cmpIrq & ~(cmpOn | $past(cmpOn) | $past(cmpOn, 2)
        | $past(cmpOn, 3) | $past(cmpOn, 4))) == '0)
        else $error("interrupt from halted comparator");
endmodule

bind tcmp_top tcmp_checker #(.N(N)) u_tcmp_checker (
    .clk_sys, .rst_b, .cmpOn, .cmpIrq, .cmpTrigger, .s_axi_awready, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata
);

// >>> test/tcmp_analog_model.sv
module tcmp_analog_model
    import tcmp_pkg::*;
(
    input  wire logic               clk_sys,
    input  wire logic [NUM_CMP-1:0] cmpOn,
    input  wire logic [NUM_CMP-1:0] senseLevel,
    output logic      [NUM_CMP-1:0] cmpRaw
);
    timeunit 1ns;
    timeprecision 100ps;
    initial cmpRaw = '0;
    // an unpowered core gives garbage, so toggle it to expose missing gating
    always @(posedge clk_sys)
        cmpRaw <= (senseLevel & cmpOn) | (~cmpRaw & ~cmpOn);
endmodule

// >>> test/test_triple_comparator_and_vref_control.sv
module test_triple_comparator_and_vref_control;
    timeunit 1ns;
    timeprecision 100ps;
    import tcmp_pkg::*;
    logic        clk_sys = 1'b0, rst_b = 1'b0, idleMode = 1'b0;
    logic [2:0]  senseLevel = 3'h0;
    logic [2:0]  cmpRaw, cmpOn, cmpInvert, plusInputSelect, cmpOutputPin, cmpPinDriveEn;
    logic [2:0]  cmpIrq, cmpTrigger;
    logic [5:0]  minusInputSelect;
    logic [3:0]  refLevel, s_axi_wstrb = 4'hf;
    logic        refPower, refPinDrive, refRange, refSupplySelect;
    logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rnd = 32'h0000_0000;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] seed = 32'h0000_def0;
    int          n_mismatch = 0, checked = 0, irqCnt = 0;
    wire  [7:0]  refPins = {refPower, refPinDrive, refRange, refSupplySelect, refLevel};
    wire  [4:0]  c1Pins = {minusInputSelect[1:0], plusInputSelect[0], cmpInvert[0], cmpOn[0]};

    tcmp_top u_tcmp_top (
        .clk_sys, .rst_b, .idleMode, .cmpRaw, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmpOn, .cmpInvert, .plusInputSelect,
        .minusInputSelect, .cmpOutputPin, .cmpPinDriveEn, .cmpIrq, .cmpTrigger, .refPower,
        .refPinDrive, .refRange, .refSupplySelect, .refLevel
    );
    tcmp_analog_model u_tcmp_analog_model (.clk_sys, .cmpOn, .senseLevel, .cmpRaw);

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // md selects the edge kind; rawRise is the direction of the analog result
    function automatic logic fires(logic [1:0] md, logic rawRise);
        return md == EDGE_ANY || (md == EDGE_RISE && rawRise) || (md == EDGE_FALL && !rawRise);
    endfunction
    task automatic give_verdict();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40; n++)
        begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        chk("write response", {30'h0, s_axi_bresp}, {30'h0, RESP_OKAY});
        if (n == 40) begin n_mismatch++; give_verdict(); end
    endtask
    task automatic rchk(input string nm, input logic [4:0] a, input logic [31:0] e,
                        input logic [1:0] re);
        int n;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40; n++)
        begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        chk(nm, s_axi_rdata, e);
        chk(nm, {30'h0, s_axi_rresp}, {30'h0, re});
        if (n == 40) begin n_mismatch++; give_verdict(); end
    endtask

    initial forever #4 clk_sys = ~clk_sys;
    always @(negedge clk_sys) rnd = xs();
    always @(posedge clk_sys) senseLevel[2:1] <= rnd[2:1];
    always @(posedge clk_sys) if (cmpIrq[0] === 1'b1) irqCnt <= irqCnt + 1;

    initial
    begin
        logic [31:0] v;
        logic [31:0] e;
        logic [1:0]  md;
        logic        iv, evt;
        int          base;
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        for (int i = 0; i < 5; i++) rchk("reset value", 5'(4 * i), 32'h0, RESP_OKAY);
        rchk("unmapped read", 5'h14, 32'h0, RESP_SLVERR);
        chk("reset pins", {29'h0, cmpPinDriveEn}, 32'h0000_0007);
        wr(ADDR_CTRL3, 32'hffff_7fff);
        rchk("ctrl3 masked", ADDR_CTRL3, 32'h0000_62d3, RESP_OKAY);
        rchk("event mirror", ADDR_STATUS, 32'h0000_0400, RESP_OKAY);
        chk("ctrl3 pins", {26'h0, cmpPinDriveEn[2], cmpInvert[2], plusInputSelect[2],
            minusInputSelect[5:4], cmpOn[2]}, 32'h0000_001e);
        wr(ADDR_CTRL3, 32'h0000_0000);
        for (int i = 0; i < 4; i++)
        begin
            v = (i == 0) ? 32'hffff_ffff : rnd;
            e = v & 32'h0000_00ff;
            wr(ADDR_REF, v);
            rchk("ref readback", ADDR_REF, e, RESP_OKAY);
            chk("ref pins", {24'h0, refPins}, e);
        end
        for (int m = 0; m < 8; m++)
        begin
            md = m[2:1];
            iv = m[0];
            v = {16'h0000, 1'b1, 1'b0, iv, 3'h0, 2'h0, md, 1'b0, iv, 2'h0, md};
            senseLevel[0] <= 1'b0;
            repeat (2)
            begin
                wr(ADDR_CTRL1, v);
                repeat (8) @(posedge clk_sys);
            end
            base = irqCnt;
            senseLevel[0] <= 1'b1;
            repeat (8) @(posedge clk_sys);
            chk("rising event", 32'(irqCnt - base), {31'h0, fires(md, 1'b1)});
            senseLevel[0] <= 1'b0;
            repeat (8) @(posedge clk_sys);
            evt = fires(md, 1'b1) || fires(md, 1'b0);
            chk("event count", 32'(irqCnt - base), {31'h0, evt});
            rchk("ctrl1 state", ADDR_CTRL1, v | {22'h0, evt, iv, 8'h0}, RESP_OKAY);
            rchk("status mirror", ADDR_STATUS, {23'h0, evt, 7'h0, iv}, RESP_OKAY);
            chk("ctrl1 pins", {27'h0, c1Pins}, {27'h0, md, iv, iv, 1'b1});
        end
        wr(ADDR_STATUS, 32'h0000_8000);
        idleMode <= 1'b1;
        base = irqCnt;
        repeat (12) @(posedge clk_sys);
        chk("idle halt", {31'h0, cmpOn[0]}, 32'h0000_0000);
        chk("idle events", 32'(irqCnt - base), 32'h0000_0000);
        rchk("idle status", ADDR_STATUS, 32'h0000_8100, RESP_OKAY);
        wr(ADDR_STATUS, 32'h0000_0000);
        repeat (8) @(posedge clk_sys);
        chk("idle run", {31'h0, cmpOn[0]}, 32'h0000_0001);
        wr(ADDR_CTRL1, 32'h0000_c000);
        senseLevel[0] <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk("output pin", {30'h0, cmpPinDriveEn[0], cmpOutputPin[0]}, 32'h0000_0001);
        give_verdict();
    end
endmodule
